// ===== jtpi_defines.svh
// constants for the jtag programming instruction decoder
`ifndef JTPI_DEFINES_SVH
`define JTPI_DEFINES_SVH

// instruction register codes
`define JTPI_IR_W             4
`define JTPI_IR_HOLD_RESET    4'hc
`define JTPI_IR_UNLOCK        4'h4
`define JTPI_IR_COMMAND       4'h5
`define JTPI_IR_PAGE_LOAD     4'h6

// chain widths and field positions
`define JTPI_SIG_W            16
`define JTPI_CMD_W            15
`define JTPI_BYTE_W           8
`define JTPI_BYTE_MSB         7
`define JTPI_PC_W             16

// unlock signature and reset values
`define JTPI_SIGNATURE        16'ha370
`define JTPI_SIG_RESET        16'h0000
`define JTPI_CMD_RESET        15'h0000
`define JTPI_PC_RESET         16'h0000

// core hold time after release of the reset chain, in core clock cycles
`define JTPI_TIMEOUT_W        16
`define JTPI_TIMEOUT_SHORT    1024
`define JTPI_TIMEOUT_LONG     16384

// page byte must reach the page buffer within this many tck periods
`define JTPI_PB_WRITE_TCK     11

`endif

// ===== jtpi_pkg.sv
// types for the jtag programming instruction decoder
package jtpi_pkg;

  // data register placed between tdi and tdo
  typedef enum logic [2:0] {
    CHAIN_NONE,
    CHAIN_RESET,
    CHAIN_UNLOCK,
    CHAIN_COMMAND,
    CHAIN_PAGE
  } jtpi_chain_t;

endpackage

// ===== jtpi_sync.sv
// two flip-flop level synchroniser with hold enable
`timescale 1ns/1ps
module jtpi_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             en,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta;

  // meta is read by dout alone
  always_ff @(posedge clk) begin
    if (en) begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule

// ===== jtpi_prog.sv
// jtag programming instruction decoder: tck-side chains, core-side flash strobes
// Notes on behaviour
// - instruction 0xc selects hold-in-reset, which resets or releases the core.
// - hold-in-reset never resets the tap side, only the core.
// - hold-in-reset puts a one-bit reset chain between tdi and tdo in shift-dr.
// - instruction 0x4 selects the 16-bit unlock signature chain, shifted in shift-dr.
// - update-dr under unlock compares signature; programming mode only on a match.
// - instruction 0x5 selects the 15-bit command chain.
// - capture-dr under command loads the previous command's result.
// - shift-dr under command shifts result out on tdo, new command in.
// - update-dr under command presents the command to the flash inputs.
// - entering run-test/idle after an applied command gives one execute cycle.
// - instruction 0x6 selects an 8-bit byte chain, low bits of command chain.
// - update-dr under page load copies byte, writes page buffer within 11 tck.
// - page load updates alternate low/high byte, first one is low.
// - pc increments before each low byte write except the first after page load is selected.
// - last page buffer write leaves the pc inside the current page.
// - every chain shifts least significant bit first.
// - programming enabled only while signature equals 1010001101110000.
// - signature clears on power-on reset; programmer clears it on leaving.
// - after reset chain release, core stays in reset for the timeout.
`timescale 1ns/1ps
`include "jtpi_defines.svh"
module jtpi_prog
  import jtpi_pkg::*;
#(
  parameter int unsigned TIMEOUT_SHORT = `JTPI_TIMEOUT_SHORT,
  parameter int unsigned TIMEOUT_LONG  = `JTPI_TIMEOUT_LONG
) (
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  input  wire logic                    core_ce,
  input  wire logic                    tck,
  input  wire logic [`JTPI_IR_W-1:0]   ir_code,
  input  wire logic                    capture_dr,
  input  wire logic                    shift_dr,
  input  wire logic                    update_dr,
  input  wire logic                    run_idle,
  input  wire logic                    tdi,
  output logic                         tdo,
  input  wire logic                    timeout_long,
  input  wire logic [`JTPI_CMD_W-1:0]  cmd_result,
  input  wire logic                    cmd_result_valid,
  input  wire logic                    pc_load,
  input  wire logic [`JTPI_PC_W-1:0]   pc_load_addr,
  output logic                         core_reset,
  output logic                         prog_mode,
  output logic [`JTPI_CMD_W-1:0]       flash_cmd,
  output logic                         flash_cmd_valid,
  output logic                         flash_exec,
  output logic [`JTPI_BYTE_W-1:0]      pb_data,
  output logic                         pb_high,
  output logic                         pb_write,
  output logic [`JTPI_PC_W-1:0]        page_pc
);

  // ---------------- tck domain ----------------
  jtpi_chain_t               chain;
  logic [1:0]                tck_sync;
  logic                      tck_rst_n;
  logic                      res_tgl_s;
  logic                      rst_chain;
  logic [`JTPI_SIG_W-1:0]    signature;
  logic                      prog_en;
  logic [`JTPI_CMD_W-1:0]    cmd_sr;
  logic [`JTPI_CMD_W-1:0]    cmd_hold;
  logic [`JTPI_CMD_W-1:0]    res_hold;
  logic                      res_seen;
  logic                      apply_tgl;
  logic                      exec_pend;
  logic                      exec_tgl;
  logic                      run_idle_d;
  logic [`JTPI_IR_W-1:0]     ir_d;
  logic                      page_hi;
  logic                      page_first;
  logic [`JTPI_BYTE_W-1:0]   byte_hold;
  logic                      byte_hi;
  logic                      byte_first;
  logic                      load_tgl;
  logic                      page_entry;

  // ---------------- core domain ----------------
  logic [`JTPI_CMD_W-1:0]    res_core;
  logic                      res_tgl;
  logic [4:0]                core_sync;
  logic [2:0]                tgl_d;
  logic                      apply_ev;
  logic                      exec_ev;
  logic                      load_ev;
  logic [`JTPI_TIMEOUT_W-1:0] timeout_cnt;
  logic [`JTPI_TIMEOUT_W-1:0] timeout_load;
  logic                      pb_pend;

  // rst_n and result toggle brought onto tck; tck must run for reset to land
  jtpi_sync #(.WIDTH(2)) u_tck_sync (
    .clk  (tck),
    .en   (1'b1),
    .din  ({rst_n, res_tgl}),
    .dout (tck_sync)
  );
  assign tck_rst_n = tck_sync[1];
  assign res_tgl_s = tck_sync[0];

  always_comb begin
    if (ir_code == `JTPI_IR_HOLD_RESET) begin
      chain = CHAIN_RESET;
    end else if (ir_code == `JTPI_IR_UNLOCK) begin
      chain = CHAIN_UNLOCK;
    end else if (ir_code == `JTPI_IR_COMMAND) begin
      chain = CHAIN_COMMAND;
    end else if (ir_code == `JTPI_IR_PAGE_LOAD) begin
      chain = CHAIN_PAGE;
    end else begin
      chain = CHAIN_NONE;
    end
  end

  assign page_entry = (chain == CHAIN_PAGE) && (ir_d != `JTPI_IR_PAGE_LOAD);

  // tap side only ever resets from rst_n, never from core_reset
  always_ff @(posedge tck) begin
    if (!tck_rst_n) begin
      rst_chain <= 1'b0;
    end else if (shift_dr && chain == CHAIN_RESET) begin
      rst_chain <= tdi;
    end
  end

  always_ff @(posedge tck) begin
    if (!tck_rst_n) begin
      signature <= `JTPI_SIG_RESET;
    end else if (shift_dr && chain == CHAIN_UNLOCK) begin
      signature <= {tdi, signature[`JTPI_SIG_W-1:1]};
    end
  end

  // mode follows the register at each update; a failed compare clears it
  always_ff @(posedge tck) begin
    if (!tck_rst_n) begin
      prog_en <= 1'b0;
    end else if (update_dr && chain == CHAIN_UNLOCK) begin
      prog_en <= (signature == `JTPI_SIGNATURE);
    end
  end

  // command chain; page load reuses its low byte
  always_ff @(posedge tck) begin
    if (!tck_rst_n) begin
      cmd_sr <= `JTPI_CMD_RESET;
    end else if (capture_dr && chain == CHAIN_COMMAND) begin
      cmd_sr <= res_hold;
    end else if (shift_dr && chain == CHAIN_COMMAND) begin
      cmd_sr <= {tdi, cmd_sr[`JTPI_CMD_W-1:1]};
    end else if (shift_dr && chain == CHAIN_PAGE) begin
      cmd_sr <= {cmd_sr[`JTPI_CMD_W-1:`JTPI_BYTE_W], tdi,
                 cmd_sr[`JTPI_BYTE_MSB:1]};
    end
  end

  // result word is held still by the core side until its next toggle
  always_ff @(posedge tck) begin
    if (!tck_rst_n) begin
      res_hold <= `JTPI_CMD_RESET;
      res_seen <= 1'b0;
    end else if (res_tgl_s != res_seen) begin
      res_hold <= res_core;
      res_seen <= res_tgl_s;
    end
  end

  always_ff @(posedge tck) begin
    if (!tck_rst_n) begin
      cmd_hold  <= `JTPI_CMD_RESET;
      apply_tgl <= 1'b0;
    end else if (update_dr && chain == CHAIN_COMMAND) begin
      cmd_hold  <= cmd_sr;
      apply_tgl <= ~apply_tgl;
    end
  end

  // one execute event per run-test/idle entry following an update
  always_ff @(posedge tck) begin
    if (!tck_rst_n) begin
      exec_pend  <= 1'b0;
      exec_tgl   <= 1'b0;
      run_idle_d <= 1'b0;
    end else begin
      run_idle_d <= run_idle;
      if (update_dr && chain == CHAIN_COMMAND) begin
        exec_pend <= 1'b1;
      end else if (run_idle && !run_idle_d && exec_pend) begin
        exec_pend <= 1'b0;
        exec_tgl  <= ~exec_tgl;
      end
    end
  end

  always_ff @(posedge tck) begin
    if (!tck_rst_n) begin
      ir_d <= '0;
    end else begin
      ir_d <= ir_code;
    end
  end

  always_ff @(posedge tck) begin
    if (!tck_rst_n) begin
      page_hi    <= 1'b0;
      page_first <= 1'b1;
      byte_hold  <= '0;
      byte_hi    <= 1'b0;
      byte_first <= 1'b1;
      load_tgl   <= 1'b0;
    end else if (page_entry) begin
      page_hi    <= 1'b0;
      page_first <= 1'b1;
    end else if (update_dr && chain == CHAIN_PAGE) begin
      byte_hold  <= cmd_sr[`JTPI_BYTE_MSB:0];
      byte_hi    <= page_hi;
      byte_first <= page_first;
      load_tgl   <= ~load_tgl;
      page_hi    <= ~page_hi;
      page_first <= 1'b0;
    end
  end

  // tdo changes on the falling edge so the programmer samples a settled bit
  always_ff @(negedge tck) begin
    if (!tck_rst_n) begin
      tdo <= 1'b0;
    end else begin
      case (chain)
        CHAIN_RESET:   tdo <= rst_chain;
        CHAIN_UNLOCK:  tdo <= signature[0];
        CHAIN_COMMAND: tdo <= cmd_sr[0];
        CHAIN_PAGE:    tdo <= cmd_sr[0];
        default:       tdo <= 1'b0;
      endcase
    end
  end

  // ---------------- core domain ----------------
  // levels and toggles from tck; word data is stable when its toggle lands
  jtpi_sync #(.WIDTH(5)) u_core_sync (
    .clk  (core_clk),
    .en   (core_ce),
    .din  ({rst_chain, prog_en, apply_tgl, exec_tgl, load_tgl}),
    .dout (core_sync)
  );

  assign apply_ev = core_sync[2] ^ tgl_d[2];
  assign exec_ev  = core_sync[1] ^ tgl_d[1];
  assign load_ev  = core_sync[0] ^ tgl_d[0];

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tgl_d <= '0;
    end else if (core_ce) begin
      tgl_d <= core_sync[2:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prog_mode <= 1'b0;
    end else if (core_ce) begin
      prog_mode <= core_sync[3];
    end
  end

  assign timeout_load = timeout_long ? TIMEOUT_LONG[`JTPI_TIMEOUT_W-1:0]
                                     : TIMEOUT_SHORT[`JTPI_TIMEOUT_W-1:0];

  // chain level drives reset straight through, timeout only after release
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      core_reset  <= 1'b1;
      timeout_cnt <= timeout_load;
    end else if (core_ce) begin
      if (core_sync[4]) begin
        core_reset  <= 1'b1;
        timeout_cnt <= timeout_load;
      end else if (timeout_cnt != '0) begin
        timeout_cnt <= timeout_cnt - 1'b1;
      end else begin
        core_reset <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      flash_cmd       <= `JTPI_CMD_RESET;
      flash_cmd_valid <= 1'b0;
    end else if (core_ce) begin
      flash_cmd_valid <= 1'b0;
      if (apply_ev && prog_mode) begin
        flash_cmd       <= cmd_hold;
        flash_cmd_valid <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      flash_exec <= 1'b0;
    end else if (core_ce) begin
      flash_exec <= exec_ev && prog_mode;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      res_core <= `JTPI_CMD_RESET;
      res_tgl  <= 1'b0;
    end else if (core_ce && cmd_result_valid) begin
      res_core <= cmd_result;
      res_tgl  <= ~res_tgl;
    end
  end

  // pre-increment only before a later low byte, so the last high byte
  // leaves the pc on the page's final word
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      page_pc <= `JTPI_PC_RESET;
    end else if (core_ce) begin
      if (pc_load) begin
        page_pc <= pc_load_addr;
      end else if (load_ev && prog_mode && !byte_hi && !byte_first) begin
        page_pc <= page_pc + 1'b1;
      end
    end
  end

  // write lands one cycle after the pc step, well inside the tck budget
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pb_pend  <= 1'b0;
      pb_write <= 1'b0;
      pb_data  <= '0;
      pb_high  <= 1'b0;
    end else if (core_ce) begin
      pb_write <= pb_pend;
      pb_pend  <= load_ev && prog_mode;
      if (load_ev && prog_mode) begin
        pb_data <= byte_hold;
        pb_high <= byte_hi;
      end
    end
  end

endmodule

// ===== jtpi_prog_monitor.sv
// concurrent checks on the jtag programming decoder ports
`timescale 1ns/1ps
`include "jtpi_defines.svh"
module jtpi_prog_monitor #(
  parameter int unsigned TIMEOUT_SHORT = `JTPI_TIMEOUT_SHORT,
  parameter int unsigned TIMEOUT_LONG  = `JTPI_TIMEOUT_LONG
) (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       tck,
  input wire logic [3:0] ir_code,
  input wire logic       shift_dr,
  input wire logic       update_dr,
  input wire logic       run_idle,
  input wire logic       tdo,
  input wire logic       timeout_long,
  input wire logic       core_reset,
  input wire logic       prog_mode,
  input wire logic       flash_cmd_valid,
  input wire logic       flash_exec,
  input wire logic       pb_write
);
  int unsigned hi_cnt;

  // high time since core_reset rose, so an early drop shows
  always_ff @(posedge core_clk) begin
    if (!rst_n || !core_reset) hi_cnt <= 0;
    else hi_cnt <= hi_cnt + 1;
  end

  sequence s_cmd_upd;
    $rose(update_dr) && ir_code == `JTPI_IR_COMMAND && prog_mode;
  endsequence

  sequence s_page_upd;
    $rose(update_dr) && ir_code == `JTPI_IR_PAGE_LOAD && prog_mode;
  endsequence

  chk_cmd_gated: assert property (
    @(posedge core_clk) disable iff (!rst_n) flash_cmd_valid |-> prog_mode)
    else $error("flash command outside programming mode");
  chk_write_gated: assert property (
    @(posedge core_clk) disable iff (!rst_n) pb_write |-> prog_mode)
    else $error("page write outside programming mode");
  chk_cmd_apply: assert property (
    @(posedge core_clk) disable iff (!rst_n) s_cmd_upd |-> ##[2:12] flash_cmd_valid)
    else $error("command update not applied");
  chk_page_write: assert property (
    @(posedge core_clk) disable iff (!rst_n) s_page_upd |-> ##[2:88] pb_write)
    else $error("page byte not written in time");
  chk_exec_once: assert property (
    @(posedge core_clk) disable iff (!rst_n) flash_exec |=> (!flash_exec)[*8])
    else $error("execute cycle repeated");
  chk_exec_idle: assert property (
    @(posedge core_clk) disable iff (!rst_n) flash_exec |-> run_idle)
    else $error("execute cycle outside idle state");
  // the selected timeout must have elapsed, so a long setting that is ignored shows
  chk_release_wait: assert property (
    @(posedge core_clk) disable iff (!rst_n) $fell(core_reset) |->
      hi_cnt >= (timeout_long ? TIMEOUT_LONG : TIMEOUT_SHORT))
    else $error("core left reset before timeout");
  chk_unlock_src: assert property (
    @(posedge core_clk) disable iff (!rst_n) $rose(prog_mode) |-> ir_code == `JTPI_IR_UNLOCK)
    else $error("programming mode entered without unlock");
  chk_tdo_nochain: assert property (
    @(posedge tck) disable iff (!rst_n) shift_dr && !(ir_code inside {`JTPI_IR_HOLD_RESET,
      `JTPI_IR_UNLOCK, `JTPI_IR_COMMAND, `JTPI_IR_PAGE_LOAD}) |-> !tdo)
    else $error("tdo driven with no chain selected");
endmodule

// ===== jtpi_tap_model.sv
// behavioural jtag programmer stepping the tap through data scans
`timescale 1ns/1ps
module jtpi_tap_model (
  output logic       tck,
  output logic [3:0] ir_code,
  output logic       capture_dr,
  output logic       shift_dr,
  output logic       update_dr,
  output logic       run_idle,
  output logic       tdi,
  input  wire logic  tdo
);
  logic so;

  initial begin
    tck = 1'b0;
    ir_code = 4'h0;
    tdi = 1'b0;
    {capture_dr, shift_dr, update_dr, run_idle} = 4'h0;
  end

  // one tck period; tck stands still between calls
  task automatic cyc(input logic [3:0] st);
    {capture_dr, shift_dr, update_dr, run_idle} = st;
    #22 tck = 1'b1;
    so = tdo;
    #40 tck = 1'b0;
    #18;
  endtask

  task automatic idle(input int n);
    repeat (n) cyc(4'h0);
  endtask

  task automatic scan(input logic [3:0] ir, input int n, input logic [15:0] din,
                      input logic exe, output logic [15:0] dout);
    dout = 16'h0000;
    ir_code = ir;
    cyc(4'h8);
    for (int i = 0; i < n; i++) begin
      tdi = din[i];
      cyc(4'h4);
      dout[i] = so;
    end
    tdi = ~tdi; // no stale level once shifting ends
    cyc(4'h2);
    if (exe) cyc(4'h1);
    cyc(4'h0);
  endtask
endmodule

// ===== testbench.sv
// self-checking bench for the jtag programming instruction decoder
`timescale 1ns/1ps
`include "jtpi_defines.svh"
module testbench;
  localparam int unsigned TS = 40;
  localparam int unsigned TL = 120;
  logic        core_clk, rst_n, core_ce, timeout_long, cmd_result_valid, pc_load;
  logic        tck, capture_dr, shift_dr, update_dr, run_idle, tdi, tdo;
  logic        core_reset, prog_mode, flash_cmd_valid, flash_exec, pb_high, pb_write;
  logic [3:0]  ir_code;
  logic [7:0]  pb_data, b;
  logic [14:0] cmd_result, flash_cmd, last_cmd, r, c;
  logic [15:0] pc_load_addr, page_pc, dout, pc0;
  logic [24:0] wr_q[$];
  int          miscompares, check_count, n_cmd, n_exec, ne;

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  jtpi_prog #(.TIMEOUT_SHORT(TS), .TIMEOUT_LONG(TL)) i_dut (
    .core_clk, .rst_n, .core_ce, .tck, .ir_code, .capture_dr, .shift_dr, .update_dr,
    .run_idle, .tdi, .tdo, .timeout_long, .cmd_result, .cmd_result_valid, .pc_load,
    .pc_load_addr, .core_reset, .prog_mode, .flash_cmd, .flash_cmd_valid, .flash_exec,
    .pb_data, .pb_high, .pb_write, .page_pc);
  jtpi_tap_model i_tap (
    .tck, .ir_code, .capture_dr, .shift_dr, .update_dr, .run_idle, .tdi, .tdo);

  always @(negedge core_clk) begin
    if (pb_write === 1'b1) wr_q.push_back({page_pc, pb_high, pb_data});
    if (flash_cmd_valid === 1'b1) begin
      n_cmd++;
      last_cmd = flash_cmd;
    end
    if (flash_exec === 1'b1) n_exec++;
  end

  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // word address steps before each low byte except the first
  function automatic logic [24:0] exp_wr(input logic [15:0] a, input int k, input logic [7:0] d);
    return {a + 16'(k / 2), k[0], d};
  endfunction

  task automatic pulse_in(input logic pc, input logic [15:0] v);
    @(negedge core_clk);
    pc_load = pc;
    cmd_result_valid = !pc;
    pc_load_addr = v;
    cmd_result = v[14:0];
    @(negedge core_clk);
    pc_load = 1'b0;
    cmd_result_valid = 1'b0;
  endtask

  task automatic finish_test;
    if (miscompares == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #400000;
    miscompares++;
    finish_test();
  end

  initial begin
    rst_n = 1'b0;
    core_ce = 1'b1;
    timeout_long = 1'b0;
    cmd_result_valid = 1'b0;
    pc_load = 1'b0;
    cmd_result = 15'h0000;
    pc_load_addr = 16'h0000;
    void'($urandom(56));
    // tck side reset needs tck edges as well
    fork
      i_tap.idle(5);
      repeat (12) @(negedge core_clk);
    join
    rst_n = 1'b1;
    cmp("prog_mode", 0, prog_mode);
    repeat (30) @(negedge core_clk);
    cmp("core_reset", 1, core_reset);
    repeat (20) @(negedge core_clk);
    cmp("core_reset", 0, core_reset);
    i_tap.idle(4);
    timeout_long = 1'b1;
    i_tap.scan(4'hc, 1, 16'h0001, 1'b0, dout);
    cmp("core_reset", 1, core_reset);
    i_tap.scan(4'hc, 1, 16'h0000, 1'b0, dout);
    cmp("reset chain", 1, dout);
    repeat (40) @(negedge core_clk);
    cmp("core_reset", 1, core_reset);
    repeat (90) @(negedge core_clk);
    cmp("core_reset", 0, core_reset);
    timeout_long = 1'b0;
    i_tap.scan(4'h5, 15, 16'h1234, 1'b0, dout);
    i_tap.scan(4'h6, 8, 16'h0055, 1'b0, dout);
    cmp("refused", 0, n_cmd + wr_q.size());
    i_tap.scan(4'hf, 8, 16'($urandom), 1'b0, dout);
    cmp("tdo no chain", 0, dout);
    i_tap.scan(4'h4, 16, 16'ha371, 1'b0, dout);
    cmp("prog_mode", 0, prog_mode);
    i_tap.scan(4'h4, 16, `JTPI_SIGNATURE, 1'b0, dout);
    cmp("prog_mode", 1, prog_mode);
    cmp("unlock out", 16'ha371, dout);
    for (int i = 0; i < 6; i++) begin
      r = (i == 0) ? 15'h7fff : 15'($urandom);
      c = (i == 1) ? 15'h0000 : 15'($urandom);
      ne = n_exec;
      pulse_in(1'b0, {1'b0, r});
      i_tap.idle(4);
      i_tap.scan(4'h5, 15, {1'b0, c}, i[0], dout);
      cmp("result out", r, dout);
      cmp("flash_cmd", c, last_cmd);
      cmp("exec count", ne + i[0], n_exec);
    end
    pc0 = 16'($urandom) & 16'h7ffe;
    pulse_in(1'b1, pc0);
    for (int k = 0; k < 4; k++) begin
      b = (k == 3) ? 8'hff : 8'($urandom);
      i_tap.scan(4'h6, 8, {8'h00, b}, 1'b0, dout);
      cmp("page write", exp_wr(pc0, k, b), wr_q.pop_front());
    end
    cmp("page_pc", pc0 + 16'h0001, page_pc);
    i_tap.scan(4'h6, 8, 16'h00a5, 1'b0, dout);
    i_tap.scan(4'h5, 15, 16'h0000, 1'b0, dout);
    i_tap.scan(4'h6, 8, 16'h005a, 1'b0, dout);
    cmp("reentry half", 0, wr_q[$][8]);
    i_tap.scan(4'hc, 1, 16'h0001, 1'b0, dout);
    cmp("prog_mode", 1, prog_mode);
    i_tap.scan(4'hc, 1, 16'h0000, 1'b0, dout);
    i_tap.scan(4'h4, 16, 16'h0000, 1'b0, dout);
    cmp("prog_mode", 0, prog_mode);
    ne = n_cmd;
    i_tap.scan(4'h5, 15, 16'h0abc, 1'b0, dout);
    cmp("cmd count", ne, n_cmd);
    finish_test();
  end
endmodule

bind jtpi_prog jtpi_prog_monitor #(
  .TIMEOUT_SHORT(TIMEOUT_SHORT),
  .TIMEOUT_LONG(TIMEOUT_LONG)
) i_mon (
  .core_clk, .rst_n, .tck, .ir_code, .shift_dr, .update_dr, .run_idle, .tdo, .timeout_long,
  .core_reset, .prog_mode, .flash_cmd_valid, .flash_exec, .pb_write);
